// *** tcdist_pkg.sv ***
package tcdist_pkg;
  // ***************************************************
  // command codes
  // ***************************************************
  localparam logic [3:0] TCD_CMD_IDLE = 4'h0;
  localparam logic [3:0] TCD_CMD_CLEAR = 4'h1;
  localparam logic [3:0] TCD_CMD_RESET = 4'h2;
  localparam logic [3:0] TCD_CMD_SPARE = 4'h3;
  localparam logic [3:0] TCD_CMD_TRIG_BASE = 4'h4;
  localparam logic [3:0] TCD_CMD_PULSE_BASE = 4'h8;
  // ***************************************************
  // widths and timing
  // ***************************************************
  localparam int TCD_CMD_W = 4;
  localparam int TCD_TOKEN_W = 12;
  localparam int TCD_DAQ_W = 4;
  localparam int TCD_CNT_W = 32;
  localparam int TCD_PHASE_W = 5;
  localparam int TCD_STEP_NS = 12;
  localparam int TCD_MCLK_NS = 25;
  // delay taps per 12 ns step; at least one mclk cycle
  localparam int TCD_STEP_CYC =
    (TCD_STEP_NS + TCD_MCLK_NS - 1) / TCD_MCLK_NS;
  localparam int TCD_DLY_DEPTH = 32;
  localparam logic [TCD_PHASE_W-1:0] TCD_PHASE_RST = 5'h00;
  localparam logic [TCD_TOKEN_W-1:0] TCD_TOKEN_FIRST = 12'h001;
  typedef enum logic [1:0] {
    TCD_GRP_NONE,
    TCD_GRP_ONE,
    TCD_GRP_TWO,
    TCD_GRP_THREE
  } tcd_group_e;
endpackage

// *** tcdist_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// link between driver and readout receiver
interface tcdist_if;
  import tcdist_pkg::*;
  logic strobe; // phase-shifted beam-crossing strobe
  logic [TCD_CMD_W-1:0] cmd; // trigger command word
  logic [TCD_TOKEN_W-1:0] token; // trigger token
  logic [TCD_DAQ_W-1:0] daq; // daq command word
  logic busy; // detector busy, receiver to driver
  modport drv (
    output strobe, cmd, token, daq,
    input busy
  );
  modport rcv (
    input strobe, cmd, token, daq,
    output busy
  );
endinterface
`default_nettype wire

// *** tcdist_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// trigger/clock driver: phase-delayed strobe + words
// ***************************************************
module tcdist_driver
  import tcdist_pkg::*;
#(
  parameter int DEPTH = TCD_DLY_DEPTH
) (
  input wire logic mclk_i, // sampling clock, 40 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic strobe_i, // raw beam strobe pin
  input wire logic [TCD_PHASE_W-1:0] jumper_i, // phase jumpers
  input wire logic cmd_req_i, // request to send command
  input wire logic [TCD_CMD_W-1:0] cmd_i, // requested command
  input wire logic [TCD_DAQ_W-1:0] daq_i, // daq word
  output logic cmd_ack_o, // command taken this period
  output logic [TCD_PHASE_W-1:0] phase_o, // readable setting
  output logic [TCD_TOKEN_W-1:0] token_o, // token on the link, zero for idle and group one
  output logic busy_o, // synced busy level
  tcdist_if.drv link // link to receivers
);
  // ***************************************************
  // strobe input sync, three stages
  // ***************************************************
  logic [2:0] ssync_r;
  logic sclean_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ssync_r <= 3'h0;
      sclean_r <= 1'b0;
    end else begin
      ssync_r <= {ssync_r[1:0], strobe_i};
      // change counts when stages two and three agree
      if (ssync_r[1] == ssync_r[2]) begin
        sclean_r <= ssync_r[2];
      end
    end
  end
  // ***************************************************
  // jumper capture: latched after reset, never written
  // ***************************************************
  logic [TCD_PHASE_W-1:0] phase_r;
  logic strap_done_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_r <= TCD_PHASE_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      phase_r <= jumper_i; // single shifter for board
      strap_done_r <= 1'b1;
    end
  end
  assign phase_o = phase_r; // readout only, no write path
  // ***************************************************
  // delay line: 12 ns steps rounded up to one 25 ns tap, over four strobe periods
  // ***************************************************
  // limitation: mclk is 25 ns, so each step rounds up to one tap
  logic [DEPTH-1:0] dly_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[DEPTH-2:0], sclean_r};
    end
  end
  logic [TCD_PHASE_W-1:0] tap;
  always_comb begin
    tap = phase_r * TCD_PHASE_W'(TCD_STEP_CYC);
  end
  logic strobe_r;
  logic strobe_q_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_r <= 1'b0;
      strobe_q_r <= 1'b0;
    end else begin
      strobe_r <= dly_r[tap]; // delayed strobe
      strobe_q_r <= strobe_r;
    end
  end
  // every link signal but busy derives from this one strobe
  assign link.strobe = strobe_r;
  wire fall = strobe_q_r & ~strobe_r; // change words here
  // ***************************************************
  // busy sync (receiver domain level)
  // ***************************************************
  logic [2:0] bsync_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bsync_r <= 3'h0;
      busy_o <= 1'b0;
    end else begin
      bsync_r <= {bsync_r[1:0], link.busy};
      if (bsync_r[1] == bsync_r[2]) begin
        busy_o <= bsync_r[2];
      end
    end
  end
  // ***************************************************
  // command launch on falling edge, stable at rising
  // ***************************************************
  logic [TCD_CMD_W-1:0] cmd_r;
  logic [TCD_TOKEN_W-1:0] tok_r;
  logic [TCD_TOKEN_W-1:0] next_tok_r;
  logic [TCD_DAQ_W-1:0] daq_r;
  wire grp1 = (cmd_i < TCD_CMD_TRIG_BASE);
  // group 1 always goes; readout commands wait for not busy
  wire take = fall & cmd_req_i & (grp1 | ~busy_o);
  always_comb begin
    cmd_ack_o = take;
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_r <= TCD_CMD_IDLE;
      tok_r <= '0;
      daq_r <= '0;
      next_tok_r <= TCD_TOKEN_FIRST;
    end else if (fall) begin
      if (take && !grp1) begin
        cmd_r <= cmd_i;
        tok_r <= next_tok_r; // unique nonzero token
        daq_r <= daq_i;
        // skip zero on wrap
        if (next_tok_r == '1) begin
          next_tok_r <= TCD_TOKEN_FIRST;
        end else begin
          next_tok_r <= next_tok_r + 1'b1;
        end
      end else if (take) begin
        cmd_r <= cmd_i; // broadcast on strobe
        tok_r <= '0; // zero token and daq
        daq_r <= '0;
      end else begin
        cmd_r <= TCD_CMD_IDLE; // idle fill
        tok_r <= '0;
        daq_r <= '0;
      end
    end
  end
  // word held across rising edge for capture
  assign link.cmd = cmd_r;
  assign link.token = tok_r;
  assign link.daq = daq_r;
  assign token_o = tok_r;
endmodule
`default_nettype wire

// *** tcdist_receiver.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// readout board receiver, runs on the link strobe
// ***************************************************
module tcdist_receiver
  import tcdist_pkg::*;
(
  input wire logic mclk_i, // local clock, 40 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic busy_i, // front-end busy level
  output logic event_o, // readout event pulse (strobe dom)
  output logic [1:0] trig_type_o, // readout type
  output logic pulse_o, // fire pulser pulse
  output logic [1:0] pulser_o, // pulser number
  output logic [TCD_TOKEN_W-1:0] token_o, // event token
  output logic [TCD_DAQ_W-1:0] daq_o, // event daq word
  output logic fe_reset_o, // front-end reset pulse
  output logic [TCD_CNT_W-1:0] count_o, // redundancy counter
  output logic [TCD_CNT_W-1:0] count_m_o, // mclk-domain copy
  output tcd_group_e group_o, // class of last command
  tcdist_if.rcv link // link from driver
);
  // ***************************************************
  // capture on rising strobe, one command per period
  // ***************************************************
  logic [TCD_CMD_W-1:0] cmd_r;
  logic [TCD_TOKEN_W-1:0] tok_r;
  logic [TCD_DAQ_W-1:0] daq_r;
  always_ff @(posedge link.strobe or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_r <= TCD_CMD_IDLE;
      tok_r <= '0;
      daq_r <= '0;
    end else begin
      cmd_r <= link.cmd;
      tok_r <= link.token;
      daq_r <= link.daq;
    end
  end
  // ***************************************************
  // decode latched word
  // ***************************************************
  always_ff @(posedge link.strobe or negedge nrst_i) begin
    if (!nrst_i) begin
      event_o <= 1'b0;
      pulse_o <= 1'b0;
      fe_reset_o <= 1'b0;
      trig_type_o <= 2'h0;
      pulser_o <= 2'h0;
      token_o <= '0;
      daq_o <= '0;
      group_o <= TCD_GRP_NONE;
    end else begin
      event_o <= 1'b0;
      pulse_o <= 1'b0;
      fe_reset_o <= 1'b0;
      if (cmd_r[3:2] == 2'h1) begin
        // all four types pass straight through on cmd_r[1:0]; this board has no reserved ones
        trig_type_o <= cmd_r[1:0];
        event_o <= 1'b1;
        token_o <= tok_r;
        daq_o <= daq_r;
        group_o <= TCD_GRP_TWO;
      end else if (cmd_r[3]) begin
        pulse_o <= 1'b1;
        pulser_o <= cmd_r[1:0];
        if (tok_r != '0) begin
          event_o <= 1'b1; // final pulse reads out
          token_o <= tok_r;
          daq_o <= daq_r;
          group_o <= TCD_GRP_TWO;
        end else begin
          group_o <= TCD_GRP_THREE; // no readout
        end
      end else if (cmd_r == TCD_CMD_RESET) begin
        fe_reset_o <= 1'b1;
        group_o <= TCD_GRP_ONE;
      end else if (cmd_r == TCD_CMD_CLEAR) begin
        group_o <= TCD_GRP_ONE;
      end else begin
        // idle and spare do nothing
        group_o <= TCD_GRP_ONE;
      end
    end
  end
  // ***************************************************
  // redundancy counter, every strobe
  // ***************************************************
  always_ff @(posedge link.strobe or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= '0;
    end else if (cmd_r == TCD_CMD_CLEAR) begin
      count_o <= '0;
    end else begin
      count_o <= count_o + 1'b1;
    end
  end
  // ***************************************************
  // counter to mclk: toggle handshake on a stable copy
  // ***************************************************
  // why: strobe period is long, so the copy holds for sampling
  logic [TCD_CNT_W-1:0] hold_r;
  logic tgl_r;
  always_ff @(posedge link.strobe or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_r <= '0;
      tgl_r <= 1'b0;
    end else begin
      hold_r <= count_o;
      tgl_r <= ~tgl_r;
    end
  end
  logic [2:0] tsync_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tsync_r <= 3'h0;
      count_m_o <= '0;
    end else begin
      tsync_r <= {tsync_r[1:0], tgl_r};
      if (tsync_r[1] != tsync_r[2]) begin
        count_m_o <= hold_r;
      end
    end
  end
  // busy level passes straight out; driver syncs it
  assign link.busy = busy_i;
endmodule
`default_nettype wire

// *** tcdist_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// link checker, sits beside the driver-receiver link
// ***************************************************
module tcdist_properties
  import tcdist_pkg::*;
(
  input wire logic mclk_i, // driver clock
  input wire logic nrst_i, // async reset, active low
  input wire logic strobe, // delayed strobe
  input wire logic [TCD_CMD_W-1:0] cmd, // command word
  input wire logic [TCD_TOKEN_W-1:0] token, // trigger token
  input wire logic [TCD_DAQ_W-1:0] daq, // daq word
  input wire logic busy // busy level
);
  logic grp1_w; // non-readout command on the link
  logic rdo_w; // trigger readout command on the link
  logic strobe_r; // strobe seen one mclk earlier
  logic [7:0] still_r; // mclk cycles since strobe moved
  assign grp1_w = cmd < TCD_CMD_TRIG_BASE;
  assign rdo_w = (cmd >= TCD_CMD_TRIG_BASE) && (cmd < TCD_CMD_PULSE_BASE);
  // stall counter: a strobe that stops would freeze every board
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      still_r <= 8'h00;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= strobe;
      if (strobe_r != strobe) begin
        still_r <= 8'h00;
      end else if (still_r != 8'hff) begin
        still_r <= still_r + 8'h01;
      end
    end
  end
  // three strobe edges in a row with the detector busy
  sequence busy_run_s;
    busy ##1 busy ##1 busy;
  endsequence
  property no_read_busy_p;
    @(posedge strobe) disable iff (!nrst_i) busy_run_s |-> !rdo_w;
  endproperty
  grp1_token_a: assert property (@(posedge strobe) disable iff (!nrst_i)
    grp1_w |-> token == '0) else $error("token not zero on group one");
  grp1_daq_a: assert property (@(posedge strobe) disable iff (!nrst_i)
    grp1_w |-> daq == '0) else $error("daq word not zero on group one");
  trig_token_a: assert property (@(posedge strobe) disable iff (!nrst_i)
    rdo_w |-> token != '0) else $error("readout sent with zero token");
  token_fresh_a: assert property (@(posedge strobe) disable iff (!nrst_i)
    rdo_w && $past(rdo_w) |-> token != $past(token))
    else $error("back to back readouts share a token");
  cmd_setup_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(strobe) |-> $stable(cmd) && $stable(token))
    else $error("command moved at strobe rise");
  sync_change_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $changed(cmd) |-> !strobe) else $error("command moved while strobe high");
  strobe_alive_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    still_r < 8'd60) else $error("delayed strobe stopped");
  busy_block_a: assert property (no_read_busy_p)
    else $error("readout sent while busy");
endmodule
`default_nettype wire

// *** trigger_command_distribution_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// bench: driver and receiver back to back
// ***************************************************
module trigger_command_distribution_tb;
  import tcdist_pkg::*;
  logic mclk = 1'b0; // 40 MHz clock
  logic nrst = 1'b0; // reset, active low
  logic strobe_raw = 1'b0; // raw beam strobe, own phase
  logic [4:0] jumper = 5'h03; // phase jumpers
  logic req = 1'b0; // command request
  logic [3:0] cmd_c = 4'h0; // requested command
  logic [3:0] daq_c = 4'h0; // requested daq word
  logic busy_fe = 1'b0; // front-end busy
  logic ack, ev, pulse, fer;
  logic [4:0] phase;
  logic [1:0] ttype, pnum;
  logic [11:0] rtok;
  logic [3:0] rdaq;
  logic [31:0] cnt;
  tcd_group_e grp;
  int n_mismatch = 0; // mismatches seen
  int checked = 0; // comparisons made
  int m0, m1, acks;
  always #12.5 mclk = ~mclk;
  // strobe slow enough that one pulse never hides behind the delay
  initial begin
    #7.3;
    forever #306 strobe_raw = ~strobe_raw;
  end
  tcdist_if tcdist_if_i ();
  tcdist_driver tcdist_driver_i (.mclk_i(mclk), .nrst_i(nrst),
    .strobe_i(strobe_raw), .jumper_i(jumper), .cmd_req_i(req),
    .cmd_i(cmd_c), .daq_i(daq_c), .cmd_ack_o(ack), .phase_o(phase),
    .token_o(), .busy_o(), .link(tcdist_if_i));
  tcdist_receiver tcdist_receiver_i (.mclk_i(mclk), .nrst_i(nrst),
    .busy_i(busy_fe), .event_o(ev), .trig_type_o(ttype), .pulse_o(pulse),
    .pulser_o(pnum), .token_o(rtok), .daq_o(rdaq), .fe_reset_o(fer),
    .count_o(cnt), .count_m_o(), .group_o(grp), .link(tcdist_if_i));
  tcdist_properties tcdist_properties_i (.mclk_i(mclk), .nrst_i(nrst),
    .strobe(tcdist_if_i.strobe), .cmd(tcdist_if_i.cmd),
    .token(tcdist_if_i.token), .daq(tcdist_if_i.daq),
    .busy(tcdist_if_i.busy));
  // ***************************************************
  // tasks
  // ***************************************************
  task report_and_stop;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task do_reset(input logic [4:0] j);
    nrst = 1'b0;
    jumper = j;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
  endtask
  // request, wait for the take, then for the decode edge, the second strobe rise
  task issue(input logic [3:0] c, input logic [3:0] d);
    int i;
    @(posedge mclk);
    #1 req = 1'b1;
    cmd_c = c;
    daq_c = d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 200);
    chk(ack, 1);
    #1 req = 1'b0;
    @(posedge tcdist_if_i.strobe);
    @(posedge tcdist_if_i.strobe);
    #1;
  endtask
  // mclk edges from a sampled raw rise to the delayed rise
  task meas(output int c);
    c = 0;
    do @(posedge mclk); while (strobe_raw !== 1'b0);
    do @(posedge mclk); while (strobe_raw !== 1'b1);
    while (tcdist_if_i.strobe !== 1'b1) begin
      @(posedge mclk);
      c++;
    end
  endtask
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    do_reset(5'h03);
    repeat (4) @(posedge mclk);
    #1 chk(phase, 5'h03);
    chk(grp, TCD_GRP_NONE);
    meas(m0);
    // all four trigger types, one every second period
    for (int n = 0; n < 4; n++) begin
      issue(4'(TCD_CMD_TRIG_BASE + n), 4'(n + 5));
      chk(ev, 1);
      chk(ttype, n);
      chk(rtok, n + 1);
      chk(rdaq, n + 5);
      chk(grp, TCD_GRP_TWO);
    end
    for (int n = 0; n < 4; n++) begin
      issue(4'(TCD_CMD_PULSE_BASE + n), 4'h0);
      chk(pulse, 1);
      chk(pnum, n);
    end
    issue(TCD_CMD_CLEAR, 4'h0);
    chk(cnt, 0);
    chk(grp, TCD_GRP_ONE);
    chk(ev, 0);
    repeat (3) @(posedge tcdist_if_i.strobe);
    #1 chk(cnt, 3);
    issue(TCD_CMD_RESET, 4'h0);
    chk(fer, 1);
    issue(TCD_CMD_SPARE, 4'h0);
    chk(fer, 0);
    chk(ev, 0);
    chk(pulse, 0);
    @(posedge tcdist_if_i.strobe);
    #1 chk(tcdist_if_i.cmd, TCD_CMD_IDLE);
    chk(tcdist_if_i.token, 0);
    chk(ev, 0);
    // readout refused while busy, group one still goes
    @(posedge mclk);
    #1 busy_fe = 1'b1;
    // let busy pass the driver's three-stage sync before asking
    repeat (8) @(posedge mclk);
    #1 req = 1'b1;
    cmd_c = TCD_CMD_TRIG_BASE;
    acks = 0;
    repeat (80) begin
      @(posedge mclk);
      if (ack === 1'b1) acks++;
    end
    chk(acks, 0);
    #1 req = 1'b0;
    issue(TCD_CMD_CLEAR, 4'h0);
    chk(cnt, 0);
    busy_fe = 1'b0;
    // second reset with another jumper setting shifts the strobe
    do_reset(5'h07);
    meas(m1);
    chk(m1 - m0, 4 * TCD_STEP_CYC);
    chk(phase, 5'h07);
    report_and_stop;
  end
endmodule
`default_nettype wire
